// [adc_ctl_defines.vh]
`ifndef ADC_CTL_DEFINES_VH
`define ADC_CTL_DEFINES_VH

// ----------------------------------------
// Register addresses
// ----------------------------------------
`define ADDR_RESULT_LOW 8'hbd
`define ADDR_RESULT_HIGH 8'hbe
`define ADDR_CONTROL 8'he8

// ----------------------------------------
// Reset values
// ----------------------------------------
`define RESET_BYTE 8'h00
`define RESET_RESULT 10'h000

// ----------------------------------------
// Control register bit positions
// ----------------------------------------
`define BIT_ENABLE 7
`define BIT_TRACK 6
`define BIT_DONE 5
`define BIT_BUSY 4
`define BIT_WINDOW 3
`define SRC_MSB 2
`define SRC_LSB 0

// ----------------------------------------
// Start source codes
// ----------------------------------------
`define SRC_SOFTWARE 3'h0
`define SRC_TIMER_A 3'h1
`define SRC_TIMER_B 3'h2
`define SRC_TIMER_C 3'h3
`define SRC_PIN 3'h4

// ----------------------------------------
// Timing in converter clocks
// ----------------------------------------
`define TRACK_CLOCKS 4'h3
`define CONV_CLOCKS_8 4'hc
`define CONV_CLOCKS_10 4'he
`define COUNT_ONE 4'h1
`define COUNT_ZERO 4'h0

// ----------------------------------------
// Result field helpers
// ----------------------------------------
`define ZERO_6 6'h00
`define ZERO_8 8'h00

`endif

// [adc_result_and_control.v]
`include "adc_ctl_defines.vh"

module adc_result_and_control (
  input wire clock,
  input wire resetn,
  input wire clock_enable,
  input wire [7:0] sfr_addr,
  input wire sfr_write,
  input wire [7:0] sfr_wdata,
  input wire bit_write,
  input wire [7:0] bit_addr,
  input wire [2:0] bit_index,
  input wire bit_value,
  input wire left_justify_select,
  input wire eight_bit_mode_select,
  input wire sar_tick,
  input wire [9:0] sample_data,
  input wire [2:0] timer_overflow,
  input wire start_pin,
  input wire window_match,
  output reg [7:0] sfr_rdata,
  output reg converter_power,
  output reg tracking,
  output reg converting,
  output reg conversion_done_pulse
);

  // ----------------------------------------
  // States
  // ----------------------------------------
  localparam [1:0] ST_IDLE = 2'd0;
  localparam [1:0] ST_TRACK = 2'd1;
  localparam [1:0] ST_CONVERT = 2'd2;

  reg [1:0] state;
  reg [1:0] next_state;
  reg [3:0] count;
  reg [3:0] next_count;
  reg [7:0] result_high_byte;
  reg [7:0] result_low_byte;
  reg converter_enable;
  reg delayed_track_select;
  reg conversion_done_flag;
  reg conversion_busy;
  reg window_match_flag;
  reg [2:0] start_source_select;
  reg pin_last;
  reg [7:0] next_rdata;

  wire [7:0] control_value;
  wire ctl_byte_write;
  wire ctl_bit_write;
  wire [7:0] write_mask;
  wire [7:0] write_bits;
  wire busy_write_one;
  wire start_event;
  wire finish;
  wire [3:0] conv_clocks;
  wire eff_enable;
  wire eff_track;
  wire [2:0] eff_source;
  reg source_hit;

  assign control_value = {converter_enable, delayed_track_select, conversion_done_flag,
                          conversion_busy, window_match_flag, start_source_select};

  // ----------------------------------------
  // Byte and single-bit control writes
  // ----------------------------------------
  assign ctl_byte_write = sfr_write && (sfr_addr == `ADDR_CONTROL);
  assign ctl_bit_write = bit_write && (bit_addr == `ADDR_CONTROL);
  // Bit write touches one lane; byte write touches all
  assign write_mask = ctl_byte_write ? 8'hff : (ctl_bit_write ? (8'h01 << bit_index) : 8'h00);
  assign write_bits = ctl_byte_write ? sfr_wdata : {8{bit_value}};

  assign busy_write_one = write_mask[`BIT_BUSY] && write_bits[`BIT_BUSY];

  // Control values as they stand after this edge's write, so that one write
  // can enable, pick a mode and start together
  assign eff_enable = write_mask[`BIT_ENABLE] ? write_bits[`BIT_ENABLE] : converter_enable;
  assign eff_track = write_mask[`BIT_TRACK] ? write_bits[`BIT_TRACK] : delayed_track_select;
  assign eff_source = (start_source_select & ~write_mask[`SRC_MSB:`SRC_LSB])
                      | (write_bits[`SRC_MSB:`SRC_LSB] & write_mask[`SRC_MSB:`SRC_LSB]);

  // ----------------------------------------
  // Start source selection
  // ----------------------------------------
  always @* begin
    case (eff_source)
      `SRC_SOFTWARE: source_hit = busy_write_one;
      `SRC_TIMER_A: source_hit = timer_overflow[0];
      `SRC_TIMER_B: source_hit = timer_overflow[1];
      `SRC_TIMER_C: source_hit = timer_overflow[2];
      `SRC_PIN: source_hit = start_pin && !pin_last;
      default: source_hit = 1'b0;
    endcase
  end

  // Starts while busy are dropped, not queued
  assign start_event = eff_enable && (state == ST_IDLE) && source_hit;

  assign conv_clocks = eight_bit_mode_select ? `CONV_CLOCKS_8 : `CONV_CLOCKS_10;

  assign finish = (state == ST_CONVERT) && sar_tick && (count == `COUNT_ONE);

  // ----------------------------------------
  // Conversion sequencer
  // ----------------------------------------
  always @* begin
    next_state = state;
    next_count = count;
    case (state)
      ST_IDLE: begin
        if (start_event) begin
          if (eff_track) begin
            next_state = ST_TRACK;
            next_count = `TRACK_CLOCKS;
          end else begin
            next_state = ST_CONVERT;
            next_count = conv_clocks;
          end
        end
      end
      ST_TRACK: begin
        if (sar_tick) begin
          if (count == `COUNT_ONE) begin
            next_state = ST_CONVERT;
            next_count = conv_clocks;
          end else begin
            next_count = count - `COUNT_ONE;
          end
        end
      end
      ST_CONVERT: begin
        if (sar_tick) begin
          if (count == `COUNT_ONE) begin
            next_state = ST_IDLE;
            next_count = `COUNT_ZERO;
          end else begin
            next_count = count - `COUNT_ONE;
          end
        end
      end
      default: begin
        next_state = ST_IDLE;
        next_count = `COUNT_ZERO;
      end
    endcase
    // Disabling aborts a conversion in flight unless this edge is its final tick, which still finishes
    if (!eff_enable) begin
      next_state = ST_IDLE;
      next_count = `COUNT_ZERO;
    end
  end

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  always @* begin
    case (sfr_addr)
      `ADDR_RESULT_LOW: next_rdata = result_low_byte;
      `ADDR_RESULT_HIGH: next_rdata = result_high_byte;
      `ADDR_CONTROL: next_rdata = control_value;
      default: next_rdata = `ZERO_8;
    endcase
  end

  // ----------------------------------------
  // Sequencer and read data registers
  // ----------------------------------------
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state <= ST_IDLE;
      count <= `COUNT_ZERO;
      pin_last <= 1'b0;
      sfr_rdata <= `RESET_BYTE;
    end else if (clock_enable) begin
      state <= next_state;
      count <= next_count;
      pin_last <= start_pin;
      sfr_rdata <= next_rdata;
    end
  end

  // ----------------------------------------
  // Control register
  // ----------------------------------------
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      converter_enable <= 1'b0;
      delayed_track_select <= 1'b0;
      start_source_select <= `SRC_SOFTWARE;
      conversion_done_flag <= 1'b0;
      window_match_flag <= 1'b0;
      conversion_busy <= 1'b0;
    end else if (clock_enable) begin
      converter_enable <= eff_enable;
      delayed_track_select <= eff_track;
      start_source_select <= eff_source;

      // Hardware set wins over a software clear
      if (finish) begin
        conversion_done_flag <= 1'b1;
      end else if (write_mask[`BIT_DONE]) begin
        conversion_done_flag <= write_bits[`BIT_DONE];
      end
      if (window_match) begin
        window_match_flag <= 1'b1;
      end else if (write_mask[`BIT_WINDOW]) begin
        window_match_flag <= write_bits[`BIT_WINDOW];
      end

      conversion_busy <= (next_state != ST_IDLE);
    end
  end

  // ----------------------------------------
  // Result bytes
  // ----------------------------------------
  // Formatted once at completion; later mode changes do not reformat
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      result_high_byte <= `RESET_BYTE;
      result_low_byte <= `RESET_BYTE;
    end else if (clock_enable) begin
      if (finish) begin
        if (eight_bit_mode_select) begin
          result_high_byte <= sample_data[9:2];
          result_low_byte <= `ZERO_8;
        end else if (left_justify_select) begin
          result_high_byte <= sample_data[9:2];
          result_low_byte <= {sample_data[1:0], `ZERO_6};
        end else begin
          result_high_byte <= {`ZERO_6, sample_data[9:8]};
          result_low_byte <= sample_data[7:0];
        end
      end else begin
        if (sfr_write && sfr_addr == `ADDR_RESULT_HIGH) begin
          result_high_byte <= sfr_wdata;
        end
        if (sfr_write && sfr_addr == `ADDR_RESULT_LOW) begin
          result_low_byte <= sfr_wdata;
        end
      end
    end
  end

  // ----------------------------------------
  // Status outputs
  // ----------------------------------------
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      converter_power <= 1'b0;
      tracking <= 1'b0;
      converting <= 1'b0;
      conversion_done_pulse <= 1'b0;
    end else if (clock_enable) begin
      converter_power <= (next_state != ST_IDLE) || eff_enable;
      // Idle tracking happens only while enabled
      tracking <= (next_state == ST_TRACK) || (next_state == ST_IDLE && eff_enable);
      converting <= (next_state == ST_CONVERT);
      conversion_done_pulse <= finish;
    end
  end

endmodule // adc_result_and_control

// [adc_result_and_control_sva.sv]
module adc_result_and_control_sva (
  input wire clock,
  input wire resetn,
  input wire clock_enable,
  input wire [7:0] sfr_addr,
  input wire sfr_write,
  input wire [7:0] sfr_wdata,
  input wire converter_power,
  input wire tracking,
  input wire converting,
  input wire conversion_done_pulse
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);
  // ----------------------------------------
  // Control writes
  // ----------------------------------------
  sequence ctl_write;
    clock_enable && sfr_write && sfr_addr == 8'he8;
  endsequence
  // Only meaningful from idle; a start during delayed tracking is refused
  sequence sw_start(logic [3:0] top);
    ctl_write ##0 sfr_wdata[7:4] == top && sfr_wdata[2:0] == 3'h0 && !converting;
  endsequence
  chk_tm0_start: assert property (
    sw_start(4'h9) |=> converting) else $error("immediate start missed");
  chk_tm1_delay: assert property (
    sw_start(4'hd) |=> tracking && !converting) else $error("delayed track skipped");
  chk_src_refuse: assert property (
    ctl_write ##0 sfr_wdata[4] && sfr_wdata[2:0] != 3'h0 && !converting |=> !converting [*2])
    else $error("busy write started with other source");
  chk_abort_idle: assert property (
    ctl_write ##0 !sfr_wdata[7] |=> !converting) else $error("disable did not stop conversion");
  chk_off_idle: assert property (
    !converter_power |-> !converting && !tracking) else $error("activity while powered down");
  chk_phase_excl: assert property (
    !(tracking && converting)) else $error("tracking and converting together");
  chk_done_ends: assert property (
    conversion_done_pulse |-> !converting && $past(converting)) else $error("done without conversion end");
  chk_done_single: assert property (
    conversion_done_pulse |=> !conversion_done_pulse) else $error("done pulse too long");
  chk_conv_power: assert property (
    converting |-> converter_power) else $error("converting while unpowered");
endmodule // adc_result_and_control_sva

bind adc_result_and_control adc_result_and_control_sva sva_chk (.clock(clock), .resetn(resetn),
  .clock_enable(clock_enable), .sfr_addr(sfr_addr), .sfr_write(sfr_write), .sfr_wdata(sfr_wdata),
  .converter_power(converter_power), .tracking(tracking), .converting(converting),
  .conversion_done_pulse(conversion_done_pulse));

// [adc_result_and_control_tb_top.sv]
module adc_result_and_control_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 0, resetn = 0, clock_enable = 1, sfr_write = 0, bit_write = 0, bit_value = 0;
  logic left_justify_select = 0, eight_bit_mode_select = 0, sar_tick = 0, start_pin = 0, window_match = 0;
  logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, bit_addr = 8'h00;
  logic [2:0] bit_index = 3'h0, timer_overflow = 3'h0;
  logic [9:0] sample_data = 10'h000;
  wire [7:0] sfr_rdata;
  wire converter_power, tracking, converting, conversion_done_pulse;
  int fails = 0, tests_run = 0;
  typedef struct {logic lj, e8, tm; logic [9:0] s; logic [7:0] h, l; int n;} row_t;
  // 8-bit samples chosen so either bit slice gives the same byte
  row_t rows [4] = '{'{0, 0, 0, 10'h2a5, 8'h02, 8'ha5, 14}, '{1, 0, 0, 10'h2a5, 8'ha9, 8'h40, 14},
    '{0, 1, 1, 10'h2aa, 8'haa, 8'h00, 15}, '{1, 1, 0, 10'h2aa, 8'haa, 8'h00, 12}};
  adc_result_and_control uut (.clock(clock), .resetn(resetn), .clock_enable(clock_enable),
    .sfr_addr(sfr_addr), .sfr_write(sfr_write), .sfr_wdata(sfr_wdata), .bit_write(bit_write),
    .bit_addr(bit_addr), .bit_index(bit_index), .bit_value(bit_value),
    .left_justify_select(left_justify_select), .eight_bit_mode_select(eight_bit_mode_select),
    .sar_tick(sar_tick), .sample_data(sample_data), .timer_overflow(timer_overflow),
    .start_pin(start_pin), .window_match(window_match), .sfr_rdata(sfr_rdata),
    .converter_power(converter_power), .tracking(tracking), .converting(converting),
    .conversion_done_pulse(conversion_done_pulse));
  initial forever #20 clock = ~clock;
  // ----------------------------------------
  // Bus and check tasks
  // ----------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_write = 1;
    @(negedge clock);
    sfr_write = 0;
  endtask
  // Read data is registered, so one edge must pass after the address
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    sfr_addr = a;
    @(negedge clock);
    chk(sfr_rdata, exp);
  endtask
  task automatic tick;
    sar_tick = 1;
    @(negedge clock);
    sar_tick = 0;
    @(negedge clock);
  endtask
  task automatic tally_and_finish;
    if (fails == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge clock);
    fails++;
    tally_and_finish;
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (8) @(negedge clock);
    resetn = 1;
    rd(8'hbd, 8'h00);
    rd(8'hbe, 8'h00);
    rd(8'he8, 8'h00);
    rd(8'h55, 8'h00);
    foreach (rows[i]) begin
      left_justify_select = rows[i].lj;
      eight_bit_mode_select = rows[i].e8;
      sample_data = rows[i].s;
      wr(8'he8, {1'b1, rows[i].tm, 6'h10});
      chk({6'h00, tracking, converting}, {6'h00, rows[i].tm, !rows[i].tm});
      repeat (rows[i].n - 1) tick;
      rd(8'he8, {1'b1, rows[i].tm, 6'h10});
      sar_tick = 1;
      @(negedge clock);
      sar_tick = 0;
      chk({6'h00, conversion_done_pulse, converting}, 8'h02);
      @(negedge clock);
      rd(8'he8, {1'b1, rows[i].tm, 6'h20});
      rd(8'hbe, rows[i].h);
      rd(8'hbd, rows[i].l);
      rd(8'he8, {1'b1, rows[i].tm, 6'h20});
      bit_addr = 8'he8;
      bit_index = 3'h5;
      bit_write = 1;
      @(negedge clock);
      bit_write = 0;
      rd(8'he8, {1'b1, rows[i].tm, 6'h00});
    end
    wr(8'he8, 8'h91);
    rd(8'he8, 8'h81);
    timer_overflow = 3'h1;
    @(negedge clock);
    timer_overflow = 3'h0;
    rd(8'he8, 8'h91);
    wr(8'he8, 8'h00);
    rd(8'he8, 8'h00);
    chk({7'h00, converter_power}, 8'h00);
    tally_and_finish;
  end
endmodule // adc_result_and_control_tb_top
